// ==== sim/tb_tvp_irq_ctrl.sv ====
// Self-checking bench for the timer 0 interrupt block
`timescale 1ns/10ps
module tb_tvp_irq_ctrl;
    import tvp_pkg::*;
    localparam logic [15:0] BOOT = 16'h1c00;
    logic clk = 1'b0, arst_n = 1'b0, avsRead = 1'b0, avsWrite = 1'b0;
    logic countTick = 1'b0, globalIrqEnable = 1'b0, bootResetFuse = 1'b1;
    logic takeEn = 1'b0, avsWaitrequest, vecTaken, irqRequest;
    logic [7:0] avsAddress = 8'h00, timerCount = 8'h00;
    logic [3:0] avsByteenable = 4'hf;
    logic [2:0] waveformModeBits = 3'h0;
    logic [31:0] avsWritedata = 0, otherIrqPending = 0, avsReaddata, rd;
    logic [4:0] vecTakenNum, irqVecNum;
    logic [15:0] irqVecAddr, resetAddr;
    logic [18:0] ovfTab [6] = '{19'h1_0001, 19'h1_ff00, 19'h5_0001,
        19'h7_4003, 19'h3_ff01, 19'h0_ff01};
    int miscompares = 0, n_checks = 0, cyc = 0;
    tvp_irq_ctrl #(.BOOT_RESET_ADDR(BOOT)) tvp_irq_ctrl_inst (.clk, .arst_n,
        .avsAddress, .avsRead, .avsWrite, .avsByteenable, .avsWritedata,
        .avsReaddata, .avsWaitrequest, .countTick, .timerCount,
        .waveformModeBits, .globalIrqEnable, .bootResetFuse, .otherIrqPending,
        .vecTaken, .vecTakenNum, .irqRequest, .irqVecNum, .irqVecAddr,
        .resetAddr);
    tvp_core_model #(.DLY(3)) tvp_core_model_inst (.clk, .arst_n, .takeEn,
        .irqRequest, .irqVecNum, .vecTaken, .vecTakenNum);
    // ==========
    // Tasks
    task automatic end_sim();
        if (miscompares == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        avsRead <= !w;
        avsWrite <= w;
        avsAddress <= a;
        avsWritedata <= d;
        do
        begin
            @(posedge clk);
        end
        while (avsWaitrequest !== 1'b0);
        rd = avsReaddata;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
        avsWritedata <= ~d;
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdChk(logic [7:0] a, logic [31:0] exp);
        bus(1'b0, a, 0);
        chk(rd, exp);
    endtask
    task automatic waitN(int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic tick(logic [7:0] c);
        @(posedge clk);
        countTick <= 1'b1;
        timerCount <= c;
        @(posedge clk);
        countTick <= 1'b0;
    endtask
    task automatic doReset(logic f);
        @(posedge clk);
        arst_n <= 1'b0;
        bootResetFuse <= f;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask
    // ==========
    // Clock, timeout, tests
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            miscompares++;
            end_sim();
        end
    end
    initial
    begin
        doReset(1'b1);
        chk(resetAddr, RESET_VEC_ADDR);
        doReset(FUSE_PROGRAMMED);
        chk(resetAddr, BOOT);
        rdChk(8'h18, 0);
        wr(OFS_CMP_A, 32'h0000_0040);
        wr(OFS_CMP_B, 32'h0000_0041);
        @(posedge clk) globalIrqEnable <= 1'b1;
        tick(8'h40);
        rdChk(OFS_FLAGS, 32'h0000_0002);
        tick(8'h41);
        tick(8'hff);
        rdChk(OFS_FLAGS, 32'h0000_0007);
        chk(irqRequest, 0);
        wr(OFS_FLAGS, 32'h0000_0002);
        rdChk(OFS_FLAGS, 32'h0000_0005);
        wr(OFS_ENABLE, 32'h0000_0004);
        waitN(2);
        chk(irqRequest, 1);
        chk({irqVecNum, irqVecAddr}, {5'h12, 16'h0022});
        @(posedge clk) globalIrqEnable <= 1'b0;
        waitN(2);
        chk(irqRequest, 0);
        wr(OFS_ENABLE, 32'h0000_0007);
        tick(8'h40);
        @(posedge clk) globalIrqEnable <= 1'b1;
        waitN(2);
        chk({irqVecNum, irqVecAddr}, {VEC_T0_CMPA, 16'h0020});
        wr(OFS_MCU_CTRL, 32'h0000_0001);
        waitN(2);
        chk(irqVecAddr, BOOT + 16'h0020);
        @(posedge clk) takeEn <= 1'b1;
        waitN(40);
        rdChk(OFS_FLAGS, 0);
        @(posedge clk) takeEn <= 1'b0;
        wr(OFS_MCU_CTRL, 0);
        for (int n = 28; n < 32; n++)
        begin
            @(posedge clk) otherIrqPending <= 32'h0000_0001 << n;
            waitN(2);
            chk(irqVecAddr, 16'h0036 + 16'(2 * (n - 28)));
        end
        rdChk(OFS_STATUS, 32'h0000_001f);
        @(posedge clk) otherIrqPending <= 32'h4000_0004;
        waitN(2);
        chk({irqVecNum, irqVecAddr}, {5'h02, 16'h0002});
        wr(OFS_MCU_CTRL, 32'h0000_0001);
        waitN(2);
        chk(irqVecAddr, BOOT + 16'h0002);
        wr(OFS_MCU_CTRL, 0);
        @(posedge clk) otherIrqPending <= 0;
        foreach (ovfTab[i])
        begin
            wr(OFS_FLAGS, 32'h0000_0007);
            @(posedge clk) waveformModeBits <= ovfTab[i][18:16];
            tick(ovfTab[i][15:8]);
            rdChk(OFS_FLAGS, {24'h00_0000, ovfTab[i][7:0]});
        end
        tick(8'h41);
        wr(OFS_FLAGS, 32'h0000_0004);
        rdChk(OFS_FLAGS, 32'h0000_0001);
        end_sim();
    end
endmodule
bind tvp_irq_ctrl tvp_irq_ctrl_asserts #(.BOOT_RESET_ADDR(BOOT_RESET_ADDR))
    asserts_inst (.clk, .arst_n, .avsAddress, .avsRead, .avsWrite,
    .avsReaddata, .avsWaitrequest, .globalIrqEnable, .bootResetFuse,
    .otherIrqPending, .irqRequest, .irqVecNum, .irqVecAddr, .resetAddr);

// ==== sim/tvp_core_model.sv ====
// Processor core model that executes pending vectors
`timescale 1ns/10ps
module tvp_core_model
#(
    parameter int DLY = 3
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Bench control
    input wire logic takeEn,
    // Block side
    input wire logic irqRequest,
    input wire logic [4:0] irqVecNum,
    output logic vecTaken,
    output logic [4:0] vecTakenNum
);
    int waitCnt;
    always_ff @(posedge clk or negedge arst_n)
        if (!arst_n)
        begin
            waitCnt <= 0;
            vecTaken <= 1'b0;
            vecTakenNum <= 5'h00;
        end
        else if (vecTaken)
        begin
            vecTaken <= 1'b0;
            vecTakenNum <= ~vecTakenNum;
            // Stale request still shows for one cycle
            waitCnt <= -3;
        end
        else if (takeEn && irqRequest && waitCnt >= DLY)
        begin
            vecTaken <= 1'b1;
            vecTakenNum <= irqVecNum;
        end
        else
            waitCnt <= waitCnt + 1;
endmodule

// ==== sim/tvp_irq_ctrl_asserts.sv ====
// Port checks for the timer 0 interrupt block
`timescale 1ns/10ps
module tvp_irq_ctrl_asserts
#(
    parameter logic [15:0] BOOT_RESET_ADDR = 16'h3800
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Bus
    input wire logic [7:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsReaddata,
    input wire logic avsWaitrequest,
    // Core side
    input wire logic globalIrqEnable,
    input wire logic bootResetFuse,
    input wire logic [31:0] otherIrqPending,
    input wire logic irqRequest,
    input wire logic [4:0] irqVecNum,
    input wire logic [15:0] irqVecAddr,
    input wire logic [15:0] resetAddr
);
    import tvp_pkg::*;
    // ==========
    // Helpers
    logic postRst;
    logic fuseCap;
    logic rdDone;
    logic [4:0] lowOther;
    logic [15:0] vecOfs;
    assign rdDone = avsRead && !avsWaitrequest;
    assign vecOfs = {10'h000, irqVecNum, 1'b0} - 16'h0002;
    always_comb
    begin
        lowOther = VEC_NONE;
        for (int i = 16; i >= 2; i--)
            if (otherIrqPending[i])
                lowOther = 5'(i);
    end
    // Fuse as seen at the first edge after reset
    always_ff @(posedge clk or negedge arst_n)
        if (!arst_n)
        begin
            postRst <= 1'b0;
            fuseCap <= 1'b1;
        end
        else if (!postRst)
        begin
            postRst <= 1'b1;
            fuseCap <= bootResetFuse;
        end
    // ==========
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    AST_WAIT_ONE: assert property (
        (avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest)
        else $error("wait longer than one cycle");
    AST_GATE_GLOBAL: assert property (
        irqRequest |-> $past(globalIrqEnable))
        else $error("request without global enable");
    AST_VEC_ADDR: assert property (
        irqRequest |-> irqVecAddr == vecOfs ||
        irqVecAddr == BOOT_RESET_ADDR + vecOfs)
        else $error("bad vec addr");
    AST_RESET_ADDR: assert property (
        postRst |-> resetAddr == (fuseCap == FUSE_PROGRAMMED ?
        BOOT_RESET_ADDR : RESET_VEC_ADDR))
        else $error("bad reset address");
    AST_REQ_NUM: assert property (
        irqRequest |-> irqVecNum >= VEC_FIRST_IRQ)
        else $error("request without vector");
    AST_LOWEST: assert property (
        postRst && $past(globalIrqEnable) && $stable(otherIrqPending) &&
        $past(lowOther) != VEC_NONE |->
        irqRequest && irqVecNum == $past(lowOther))
        else $error("not lowest vector");
    AST_UPPER_ZERO: assert property (
        rdDone |-> avsReaddata[31:8] == 0)
        else $error("upper read bits set");
    AST_STATUS: assert property (
        rdDone && avsAddress == OFS_STATUS |->
        avsReaddata[7:0] == {3'h0, $past(irqVecNum)})
        else $error("status mismatch");
    cover property (irqRequest && irqVecNum == VEC_T0_CMPA);
    cover property (rdDone && avsAddress == OFS_STATUS);
    cover property (irqRequest && irqVecNum == 5'h1f);
endmodule

// ==== src/tvp_event_detect.sv ====
// Timer 0 compare-match and overflow event detection
`timescale 1ns/10ps
module tvp_event_detect
(
    // Timer state
    input wire logic countTick,
    input wire logic [7:0] timerCount,
    input wire logic [2:0] waveformModeBits,
    // Compare values
    input wire logic [7:0] cmpAValue,
    input wire logic [7:0] cmpBValue,
    // Events
    output logic cmpAEvent,
    output logic cmpBEvent,
    output logic ovfEvent
);
    import tvp_pkg::*;

    wire logic atMax = (timerCount == CNT_MAX);
    wire logic atBottom = (timerCount == CNT_BOTTOM);
    wire logic atTopA = (timerCount == cmpAValue);
    logic ovfPoint;

    assign cmpAEvent = countTick && atTopA;
    assign cmpBEvent = countTick && (timerCount == cmpBValue);

    // Overflow point follows the counting mode
    always_comb
    begin
        unique case (waveformModeBits)
            WGM_PC_FULL, WGM_PC_TOPA: ovfPoint = atBottom;
            WGM_FAST_TOPA: ovfPoint = atTopA;
            default: ovfPoint = atMax;
        endcase
    end

    assign ovfEvent = countTick && ovfPoint;
endmodule

// ==== src/tvp_irq_ctrl.sv ====
// Timer 0 interrupt flags, request gating and vector placement
//
// Contract
// - Compare-B match sets flag bit 2.
// - Compare-B flag cleared by vector or write-one.
// - Compare-B request needs global, enable and flag.
// - Compare-A match sets flag bit 1.
// - Compare-A flag cleared by vector or write-one.
// - Compare-A request needs global, enable and flag.
// - Timer overflow sets flag bit 0.
// - Overflow flag cleared by vector or write-one.
// - Overflow request needs global, enable and flag.
// - Overflow point follows waveform mode.
// - Vector-select moves vectors to boot section.
// - Programmed fuse starts at boot loader address.
// - Fuse one is unprogrammed, zero programmed.
// - Reset at 0 or boot; vectors from 2.
// - Vectors 28 to 31 at 0x36 to 0x3C.
//
// Register access over Avalon-MM and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module tvp_irq_ctrl
#(
    parameter logic [15:0] BOOT_RESET_ADDR = 16'h3800
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Avalon-MM slave
    input wire logic [7:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [3:0] avsByteenable,
    input wire logic [31:0] avsWritedata,
    output logic [31:0] avsReaddata,
    output logic avsWaitrequest,
    // Timer 0 state
    input wire logic countTick,
    input wire logic [7:0] timerCount,
    input wire logic [2:0] waveformModeBits,
    // Processor core
    input wire logic globalIrqEnable,
    input wire logic bootResetFuse,
    input wire logic [31:0] otherIrqPending,
    input wire logic vecTaken,
    input wire logic [4:0] vecTakenNum,
    output logic irqRequest,
    output logic [4:0] irqVecNum,
    output logic [15:0] irqVecAddr,
    output logic [15:0] resetAddr
);
    import tvp_pkg::*;

    // ==========================================================
    // State
    // ==========================================================
    logic [NFLAGS-1:0] flags_reg, flags_next;
    logic [NFLAGS-1:0] irqEnable_reg;
    logic [7:0] cmpAValue_reg;
    logic [7:0] cmpBValue_reg;
    logic vectorSelect_reg;
    logic ack_reg;
    logic [31:0] readdata_reg;
    logic fuseSeen_reg;
    logic [15:0] resetAddr_reg;
    logic irqRequest_reg;
    logic [4:0] irqVecNum_reg;
    logic [15:0] irqVecAddr_reg;

    // ==========================================================
    // Bus decode
    // ==========================================================
    wire logic busReq = avsRead || avsWrite;
    wire logic lowLane = avsByteenable[0];
    wire logic wrCommit = avsWrite && ack_reg && lowLane;
    wire logic selFlags = (avsAddress == OFS_FLAGS);
    wire logic selEnable = (avsAddress == OFS_ENABLE);
    wire logic selCmpA = (avsAddress == OFS_CMP_A);
    wire logic selCmpB = (avsAddress == OFS_CMP_B);
    wire logic selMcu = (avsAddress == OFS_MCU_CTRL);
    wire logic selStatus = (avsAddress == OFS_STATUS);
    wire logic [7:0] wrByte = avsWritedata[7:0];
    wire logic rdCapture = avsRead && !ack_reg;
    wire logic wrFlags = wrCommit && selFlags;
    wire logic wrEnable = wrCommit && selEnable;
    wire logic wrCmpA = wrCommit && selCmpA;
    wire logic wrCmpB = wrCommit && selCmpB;
    wire logic wrMcu = wrCommit && selMcu;

    // One wait state on every access
    assign avsWaitrequest = busReq && !ack_reg;
    assign avsReaddata = readdata_reg;

    // ==========================================================
    // Events
    // ==========================================================
    logic cmpAEvent, cmpBEvent, ovfEvent;

    tvp_event_detect tvp_event_detect_inst
    (
        .countTick(countTick),
        .timerCount(timerCount),
        .waveformModeBits(waveformModeBits),
        .cmpAValue(cmpAValue_reg),
        .cmpBValue(cmpBValue_reg),
        .cmpAEvent(cmpAEvent),
        .cmpBEvent(cmpBEvent),
        .ovfEvent(ovfEvent)
    );

    // ==========================================================
    // Flag set and clear
    // ==========================================================
    logic [NFLAGS-1:0] setVec, swClr, hwClr;

    // Vector whose execution clears each flag
    function automatic logic [4:0] flagVec(input int flagBit);
        logic [4:0] num;
        num = VEC_NONE;
        if (flagBit == BIT_OVF)
            num = VEC_T0_OVF;
        else if (flagBit == BIT_CMPA)
            num = VEC_T0_CMPA;
        else if (flagBit == BIT_CMPB)
            num = VEC_T0_CMPB;
        return num;
    endfunction

    assign setVec[BIT_OVF] = ovfEvent;
    assign setVec[BIT_CMPA] = cmpAEvent;
    assign setVec[BIT_CMPB] = cmpBEvent;
    assign swClr = wrFlags ? wrByte[NFLAGS-1:0] : '0;

    genvar g;
    generate
        for (g = 0; g < NFLAGS; g++)
        begin : g_hwclr
            wire logic vecHit = (vecTakenNum == flagVec(g));
            assign hwClr[g] = vecTaken && vecHit;
        end
    endgenerate

    // A set in the clearing cycle wins
    wire logic [NFLAGS-1:0] clrVec = swClr | hwClr;
    assign flags_next = (flags_reg & ~clrVec) | setVec;

    // ==========================================================
    // Request gating and vector selection
    // ==========================================================
    wire logic [NFLAGS-1:0] t0Req = flags_reg & irqEnable_reg
                                    & {NFLAGS{globalIrqEnable}};
    logic [31:0] pendingVec;
    logic anyPending;
    logic [4:0] pickNum;
    logic [15:0] pickAddr;

    always_comb
    begin
        pendingVec = otherIrqPending & {NVEC{globalIrqEnable}};
        pendingVec[VEC_RESET] = 1'b0;
        for (int i = 0; i < NFLAGS; i++)
        begin
            pendingVec[flagVec(i)] = t0Req[i];
        end
    end

    tvp_vec_pick tvp_vec_pick_inst
    (
        .pendingVec(pendingVec),
        .vectorSelect(vectorSelect_reg),
        .bootResetAddr(BOOT_RESET_ADDR),
        .anyPending(anyPending),
        .pickNum(pickNum),
        .pickAddr(pickAddr)
    );

    assign irqRequest = irqRequest_reg;
    assign irqVecNum = irqVecNum_reg;
    assign irqVecAddr = irqVecAddr_reg;
    assign resetAddr = resetAddr_reg;

    // ==========================================================
    // Read mux
    // ==========================================================
    logic [31:0] readMux;

    always_comb
    begin
        readMux = '0;
        if (selFlags)
            readMux[NFLAGS-1:0] = flags_reg;
        else if (selEnable)
            readMux[NFLAGS-1:0] = irqEnable_reg;
        else if (selCmpA)
            readMux[7:0] = cmpAValue_reg;
        else if (selCmpB)
            readMux[7:0] = cmpBValue_reg;
        else if (selMcu)
            readMux[BIT_VSEL] = vectorSelect_reg;
        else if (selStatus)
            readMux[4:0] = irqVecNum_reg;
    end

    // ==========================================================
    // Bus handshake
    // ==========================================================
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ack_reg <= 1'b0;
            readdata_reg <= '0;
        end
        else
        begin
            ack_reg <= busReq && !ack_reg;
            if (rdCapture)
                readdata_reg <= readMux;
        end
    end

    // ==========================================================
    // Software registers
    // ==========================================================
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            irqEnable_reg <= '0;
        else if (wrEnable)
            irqEnable_reg <= wrByte[NFLAGS-1:0];
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            cmpAValue_reg <= RST_BYTE;
        else if (wrCmpA)
            cmpAValue_reg <= wrByte;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            cmpBValue_reg <= RST_BYTE;
        else if (wrCmpB)
            cmpBValue_reg <= wrByte;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            vectorSelect_reg <= 1'b0;
        else if (wrMcu)
            vectorSelect_reg <= wrByte[BIT_VSEL];
    end

    // ==========================================================
    // Flags and core outputs
    // ==========================================================
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            flags_reg <= '0;
        else
            flags_reg <= flags_next;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irqRequest_reg <= 1'b0;
            irqVecNum_reg <= VEC_NONE;
            irqVecAddr_reg <= RESET_VEC_ADDR;
        end
        else
        begin
            irqRequest_reg <= anyPending;
            irqVecNum_reg <= pickNum;
            irqVecAddr_reg <= pickAddr;
        end
    end

    // ==========================================================
    // Reset address from fuse, caught after reset release
    // ==========================================================
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fuseSeen_reg <= 1'b0;
            resetAddr_reg <= RESET_VEC_ADDR;
        end
        else if (!fuseSeen_reg)
        begin
            fuseSeen_reg <= 1'b1;
            if (bootResetFuse == FUSE_PROGRAMMED)
                resetAddr_reg <= BOOT_RESET_ADDR;
            else
                resetAddr_reg <= RESET_VEC_ADDR;
        end
    end
endmodule

// ==== src/tvp_pkg.sv ====
// Shared constants for timer 0 interrupt flags and vector placement
package tvp_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_FLAGS = 8'h00;
    localparam logic [7:0] OFS_ENABLE = 8'h04;
    localparam logic [7:0] OFS_CMP_A = 8'h08;
    localparam logic [7:0] OFS_CMP_B = 8'h0C;
    localparam logic [7:0] OFS_MCU_CTRL = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    // Flag, enable and vector-select bit positions
    localparam int BIT_OVF = 0;
    localparam int BIT_CMPA = 1;
    localparam int BIT_CMPB = 2;
    localparam int BIT_VSEL = 0;
    localparam int NFLAGS = 3;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RESET_VEC_ADDR = 16'h0000;
    // Vector numbering: vector 1 is reset, vector n sits at 2*(n-1)
    localparam logic [4:0] VEC_RESET = 5'h01;
    localparam logic [4:0] VEC_FIRST_IRQ = 5'h02;
    localparam logic [4:0] VEC_T0_CMPA = 5'h11;
    localparam logic [4:0] VEC_T0_CMPB = 5'h12;
    localparam logic [4:0] VEC_T0_OVF = 5'h13;
    localparam logic [4:0] VEC_NONE = 5'h00;
    localparam int NVEC = 32;
    // Counter extremes
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    // Waveform generation modes
    localparam logic [2:0] WGM_NORMAL = 3'h0;
    localparam logic [2:0] WGM_PC_FULL = 3'h1;
    localparam logic [2:0] WGM_CTC = 3'h2;
    localparam logic [2:0] WGM_FAST_FULL = 3'h3;
    localparam logic [2:0] WGM_PC_TOPA = 3'h5;
    localparam logic [2:0] WGM_FAST_TOPA = 3'h7;
    // Boot-reset fuse encoding
    localparam logic FUSE_PROGRAMMED = 1'b0;
endpackage

// ==== src/tvp_vec_pick.sv ====
// Lowest-address pending vector selection and address forming
`timescale 1ns/10ps
module tvp_vec_pick
(
    // Requests, bit n is vector n
    input wire logic [31:0] pendingVec,
    // Placement
    input wire logic vectorSelect,
    input wire logic [15:0] bootResetAddr,
    // Result
    output logic anyPending,
    output logic [4:0] pickNum,
    output logic [15:0] pickAddr
);
    import tvp_pkg::*;

    logic [4:0] found;
    wire logic [15:0] vecBase = vectorSelect ? bootResetAddr
                                             : RESET_VEC_ADDR;

    // Lowest vector number wins
    always_comb
    begin
        found = VEC_NONE;
        for (int i = NVEC - 1; i >= int'(VEC_FIRST_IRQ); i--)
        begin
            if (pendingVec[i])
            begin
                found = 5'(i);
            end
        end
    end

    assign anyPending = (found != VEC_NONE);
    assign pickNum = found;
    // Vector n at base + 2*(n-1), so 28..31 land at 0x36..0x3C
    wire logic [4:0] slotNum = found - VEC_RESET;
    assign pickAddr = vecBase + {10'h000, slotNum, 1'b0};
endmodule
